// ===== acs_fifo.sv
/*
  acs_fifo: eight-entry result store with fill count; oldest entry is
  presented from a register.
  Assumes a clear with a write stores that write as the only entry.
*/
`timescale 1ns/1ps
module acs_fifo
  import acs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  acs_fifo_if.store f
);
  logic [RES_W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wp_r;
  logic [PTR_W-1:0] rp_r;
  logic [CNT_W-1:0] cnt_r;
  logic [RES_W-1:0] head_r;
  wire              full_w = (cnt_r == CNT_W'(FIFO_DEPTH));
  wire              wr_ok  = f.wr_en && (f.clr || !full_w);
  wire              rd_ok  = f.rd_en && !f.clr && (cnt_r != '0);
  wire [PTR_W-1:0]  wa_w   = f.clr ? '0 : wp_r;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i || f.clr) begin
      wp_r  <= wr_ok ? PTR_W'(1) : '0;
      rp_r  <= '0;
      cnt_r <= wr_ok ? CNT_W'(1) : '0;
    end else begin
      wp_r  <= wp_r + PTR_W'(wr_ok);
      rp_r  <= rp_r + PTR_W'(rd_ok);
      cnt_r <= cnt_r + CNT_W'(wr_ok) - CNT_W'(rd_ok);
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_ok && !rst_i) begin
      mem[wa_w] <= f.wr_data;
    end
    head_r <= mem[rp_r];
  end

  assign f.rd_data = head_r;
  assign f.count   = cnt_r;
endmodule

// ===== acs_fifo_if.sv
/*
  acs_fifo_if: carrier between the sequencer and its result store.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/1ps
interface acs_fifo_if;
  import acs_pkg::*;
  logic             wr_en;
  logic [RES_W-1:0] wr_data;
  logic             rd_en;
  logic             clr;
  logic [RES_W-1:0] rd_data;
  logic [CNT_W-1:0] count;
  modport ctrl  (output wr_en, wr_data, rd_en, clr, input rd_data, count);
  modport store (input wr_en, wr_data, rd_en, clr, output rd_data, count);
endinterface

// ===== acs_host_model.sv
/*
  acs_host_model: serial host with frames, triggers and the start pin.
  Assumes a 32 ns link period; link clock runs only when asked.
*/
`timescale 1ns/1ps
module acs_host_model (
  output logic      link_clk_o,
  output logic      cs_n_o,
  output logic      fs_o,
  output logic      sdi_o,
  output logic      conv_start_n_n_o,
  input  wire logic sdo_i
);
  initial begin
    link_clk_o = 1'b0;
    cs_n_o = 1'b1;
    fs_o = 1'b0;
    sdi_o = 1'b0;
    conv_start_n_n_o = 1'b1;
  end
  task automatic clk(input int n);
    repeat (n) begin
      #16 link_clk_o = 1'b1;
      #16 link_clk_o = 1'b0;
    end
  endtask
  // whole 16-bit word, msb first, then a short tail with select high
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi_o = w[i];
      clk(1);
      r[i] = sdo_i;
    end
    cs_n_o = 1'b1;
    sdi_o = ~w[0];
    clk(4);
  endtask
  task automatic cs_trig();
    cs_n_o = 1'b0;
    #64 cs_n_o = 1'b1;
  endtask
  // dsp style: select is lowered once and then left low
  task automatic fs_trig();
    cs_n_o = 1'b0;
    fs_o = 1'b1;
    #64 fs_o = 1'b0;
  endtask
  task automatic conv_start_n(input int low_ns);
    conv_start_n_n_o = 1'b0;
    #(low_ns < 800 ? 800 : low_ns);
    conv_start_n_n_o = 1'b1;
  endtask
endmodule

// ===== acs_pkg.sv
/*
  acs_pkg: constants, field positions, codes and state types of the
  conversion-mode sequencer.
  Assumes a 125 MHz core clock.
*/
package acs_pkg;
  localparam int RES_W      = 12;
  localparam int WORD_W     = 16;
  localparam int CNT_W      = 4;
  localparam int PTR_W      = 3;
  localparam int CH_W       = 4;
  localparam int FIFO_DEPTH = 8;

  // command codes, top four bits of a serial word
  localparam logic [3:0] CMD_RD_CFG  = 4'h9;
  localparam logic [3:0] CMD_WR_CFG  = 4'ha;
  localparam logic [3:0] CMD_TST_MID = 4'hb;
  localparam logic [3:0] CMD_TST_LO  = 4'hc;
  localparam logic [3:0] CMD_TST_HI  = 4'hd;
  localparam logic [3:0] CMD_RD_FIFO = 4'he;

  // configuration word fields
  localparam int CFG_MODE_LSB = 5;
  localparam int CFG_SEQ_LSB  = 3;
  localparam int CFG_PIN_BIT  = 2;
  localparam int CFG_LVL_LSB  = 0;
  localparam logic [11:0] CFG_RST = 12'h000;

  // fifo thresholds in entries
  localparam logic [3:0] THR_FULL = 4'h8;
  localparam logic [3:0] THR_3Q   = 4'h6;
  localparam logic [3:0] THR_HALF = 4'h4;
  localparam logic [3:0] THR_1Q   = 4'h2;

  // normal sampling window
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int SAMPLE_TIME_NS = 600;
  localparam int SAMPLE_CYC =
    (SAMPLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCNT_W = 8;

  typedef enum logic [1:0] {
    MODE_ONE_SHOT  = 2'b00,
    MODE_REPEAT    = 2'b01,
    MODE_SWEEP     = 2'b10,
    MODE_RPT_SWEEP = 2'b11
  } acs_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SAMPN = 4'b0010,
    ST_SAMPX = 4'b0100,
    ST_CONV  = 4'b1000
  } acs_state_e;
endpackage

// ===== acs_seq.sv
/*
  acs_seq: conversion-mode sequencer of a 12-bit serial converter.
  Assumes the serial frame (cs_n, sdi) is timed by link_clk_i, the
  analog core answers a convert pulse with adc_done_i on core_clk_i.
*/
`timescale 1ns/1ps
// How it works
// - falling conv_start_n opens the sampling window
// - rising conv_start_n closes sampling and starts conversion at once
// - after conversion, fifo read or channel select shifts the result out
// - conversion mode field picks one-shot, repeat, sweep or repeat sweep
// - triggers: conv_start_n, chip select, or frame sync
// - frame sync triggers even while chip select stays low
// - one-shot bypasses fifo; busy flag during conversion or irq after
// - repeat fills fifo from one channel; unread data is dropped, restarts
// - sweep converts listed channels in order, one per trigger, into fifo
// - sweep halts as soon as the fifo threshold is reached
// - fifo modes raise the threshold irq once per fill
// - sweep needs a fifo read then reconfigure before the next sweep
// - repeat sweep may keep sweeping after the threshold irq
// - repeat sweep: a read right after irq keeps all results in order
// - repeat sweep: no read, or new trigger, clears fifo before next store
// - repeat modes: service without fifo read clears the fifo
// - fifo modes take conv_start_n only while chip select is high
// - fifo level field: full, three quarters, half, one quarter
// - sweep sequence field used only in sweep modes
// - status pin is irq when pin_func_sel is 0 or in fifo modes, end-of-conversion when 1 in one-shot
// - fifo read code 1110 returns oldest result in top twelve bits
module acs_seq
  import acs_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             link_clk_i,
  input  wire logic             cs_n_i,
  input  wire logic             frame_sync_in_i,
  input  wire logic             sdi_i,
  output logic                  sdo_o,
  output logic                  sdo_oe_o,
  input  wire logic             conv_start_n_i,
  input  wire logic             adc_done_i,
  input  wire logic [RES_W-1:0] adc_result_i,
  output logic                  adc_sample_o,
  output logic                  adc_convert_o,
  output logic [CH_W-1:0]       adc_channel_o,
  output logic                  conversion_done_flag_o,
  output logic                  threshold_irq_n_o,
  output logic                  status_pin_o,
  output logic [CNT_W-1:0]      fifo_count_o
);
  ////////////////////////////////////////////////////////////////////
  // link domain: serial shift in and out
  logic [1:0]        lrst_s_r;
  logic [3:0]        bit_cnt_r;
  logic [14:0]       rx_sh_r;
  logic [WORD_W-1:0] rx_word_r;
  logic              rx_tog_r;
  logic [2:0]        txt_s_r;
  logic [WORD_W-1:0] tx_hold_r;
  logic [WORD_W-1:0] tx_sh_r;
  wire               lrst_w = lrst_s_r[1];

  always_ff @(posedge link_clk_i) begin
    lrst_s_r <= {lrst_s_r[0], sys_rst_i};
  end

  // cs_n and sdi are launched by the far end on this clock
  always_ff @(posedge link_clk_i) begin
    if (lrst_w || cs_n_i) begin
      bit_cnt_r <= '0;
      rx_sh_r   <= '0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      rx_sh_r   <= {rx_sh_r[13:0], sdi_i};
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst_w) begin
      rx_word_r <= '0;
      rx_tog_r  <= 1'b0;
    end else if (!cs_n_i && bit_cnt_r == 4'hf) begin
      rx_word_r <= {rx_sh_r, sdi_i};
      rx_tog_r  <= ~rx_tog_r;
    end
  end

  logic tx_tog_r;
  logic [WORD_W-1:0] tx_word_r;

  always_ff @(posedge link_clk_i) begin
    if (lrst_w) begin
      txt_s_r   <= '0;
      tx_hold_r <= '0;
    end else begin
      txt_s_r <= {txt_s_r[1:0], tx_tog_r};
      if (txt_s_r[2] ^ txt_s_r[1]) begin
        tx_hold_r <= tx_word_r;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst_w) begin
      tx_sh_r  <= '0;
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_oe_o <= ~cs_n_i;
      if (bit_cnt_r == 4'h0) begin
        sdo_o   <= tx_hold_r[15];
        tx_sh_r <= {tx_hold_r[14:0], 1'b0};
      end else begin
        sdo_o   <= tx_sh_r[15];
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // core domain: synchronisers
  logic [2:0] cs_s_r;
  logic [2:0] fs_s_r;
  logic [2:0] cst_s_r;
  logic [2:0] rxt_s_r;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cs_s_r  <= 3'h7;
      fs_s_r  <= 3'h0;
      cst_s_r <= 3'h7;
      rxt_s_r <= 3'h0;
    end else begin
      cs_s_r  <= {cs_s_r[1:0], cs_n_i};
      fs_s_r  <= {fs_s_r[1:0], frame_sync_in_i};
      cst_s_r <= {cst_s_r[1:0], conv_start_n_i};
      rxt_s_r <= {rxt_s_r[1:0], rx_tog_r};
    end
  end

  wire cs_high  = cs_s_r[1];
  wire cs_fall  = cs_s_r[2] & ~cs_s_r[1];
  wire fs_rise  = ~fs_s_r[2] & fs_s_r[1];
  wire cst_fall = cst_s_r[2] & ~cst_s_r[1];
  wire cst_rise = ~cst_s_r[2] & cst_s_r[1];

  ////////////////////////////////////////////////////////////////////
  // command decode
  wire [3:0] code_w   = rx_word_r[15:12];
  wire       cmd_v    = rxt_s_r[2] ^ rxt_s_r[1];
  wire       is_tst   = code_w == CMD_TST_MID || code_w == CMD_TST_LO ||
                        code_w == CMD_TST_HI;
  wire       is_sel   = cmd_v && (!code_w[3] || is_tst);
  wire       is_wrcfg = cmd_v && code_w == CMD_WR_CFG;
  wire       is_rdcfg = cmd_v && code_w == CMD_RD_CFG;
  wire       is_rdff  = cmd_v && code_w == CMD_RD_FIFO;

  logic [11:0] cfg_r;
  acs_mode_e   mode_w;
  assign mode_w = acs_mode_e'(cfg_r[CFG_MODE_LSB+:2]);
  wire [1:0] seq_w    = cfg_r[CFG_SEQ_LSB+:2];
  wire       pin_sel  = cfg_r[CFG_PIN_BIT];
  wire [1:0] lvl_w    = cfg_r[CFG_LVL_LSB+:2];
  wire       ff_mode  = mode_w != MODE_ONE_SHOT;
  wire       swp_mode = mode_w == MODE_SWEEP || mode_w == MODE_RPT_SWEEP;
  wire       rpt_mode = mode_w == MODE_REPEAT || mode_w == MODE_RPT_SWEEP;
  wire [3:0] thr_w    = lvl_w == 2'b00 ? THR_FULL :
                        lvl_w == 2'b01 ? THR_3Q :
                        lvl_w == 2'b10 ? THR_HALF : THR_1Q;

  // sweep channel lists, indexed by position in the sweep
  function automatic logic [2:0] seq_ch(input logic [1:0] s,
                                        input logic [2:0] i);
    logic [2:0] c;
    c = i;
    case (s)
      2'b01:   c = {i[1:0], 1'b0};
      2'b10:   c = {i[2:1], 1'b0};
      2'b11:   c = {1'b0, i[0], 1'b0};
      default: c = i;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // sequencing state
  acs_state_e       state_r;
  acs_state_e       state_nxt;
  logic [SCNT_W-1:0] samp_cnt_r;
  logic [CH_W-1:0]  chan_r;
  logic [2:0]       seq_idx_r;
  logic             halt_r;
  logic             int_r;
  logic             await_r;
  logic             reading_r;
  logic             clr_pend_r;
  logic             irq_done_r;
  logic [RES_W-1:0] last_res_r;

  acs_fifo_if ff ();

  wire blk_await = await_r && mode_w != MODE_RPT_SWEEP;
  wire run_ok    = !halt_r && !reading_r && !blk_await;
  wire norm_trig = ff_mode ? (cs_fall || fs_rise) : is_sel;
  wire ext_ok    = !ff_mode || cs_high;
  wire start_x   = state_r == ST_IDLE && run_ok && cst_fall && ext_ok;
  wire start_n   = state_r == ST_IDLE && run_ok && norm_trig && !start_x;
  wire conv_done = state_r == ST_CONV && adc_done_i;
  wire push      = conv_done && ff_mode;
  wire late_trig = await_r && mode_w == MODE_RPT_SWEEP &&
                   (start_x || start_n);
  wire svc_clr   = cmd_v && int_r && !is_rdff && rpt_mode;
  wire [3:0] base_cnt = clr_pend_r ? 4'h0 : ff.count;
  wire [3:0] new_cnt  = base_cnt + 4'h1;
  wire at_thr    = push && new_cnt == thr_w && !irq_done_r;
  wire ff_empty  = reading_r && ff.count == '0;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_x) begin
          state_nxt = ST_SAMPX;
        end else if (start_n) begin
          state_nxt = ST_SAMPN;
        end
      end
      ST_SAMPX: begin
        if (cst_rise) begin
          state_nxt = ST_CONV;
        end
      end
      ST_SAMPN: begin
        if (samp_cnt_r == '0) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (adc_done_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_r    <= ST_IDLE;
      samp_cnt_r <= '0;
    end else begin
      state_r    <= state_nxt;
      samp_cnt_r <= start_n ? SCNT_W'(SAMPLE_CYC - 1) :
                    samp_cnt_r - SCNT_W'(samp_cnt_r != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration, channel and sweep position
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cfg_r     <= CFG_RST;
      chan_r    <= '0;
      seq_idx_r <= '0;
      halt_r    <= 1'b0;
    end else begin
      if (is_wrcfg) begin
        cfg_r <= rx_word_r[11:0];
      end
      if (is_sel) begin
        chan_r <= is_tst ? code_w : {1'b0, code_w[2:0]};
      end
      if (is_wrcfg) begin
        seq_idx_r <= '0;
        halt_r    <= 1'b0;
      end else if (push && swp_mode) begin
        seq_idx_r <= seq_idx_r + 3'h1;
        if (mode_w == MODE_SWEEP &&
            (new_cnt >= thr_w || seq_idx_r == 3'h7)) begin
          halt_r <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // irq and service tracking
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || is_wrcfg) begin
      int_r      <= 1'b0;
      await_r    <= 1'b0;
      reading_r  <= 1'b0;
      clr_pend_r <= 1'b0;
      irq_done_r <= 1'b0;
    end else begin
      if ((conv_done && !ff_mode && !pin_sel) || at_thr) begin
        int_r <= 1'b1;
      end else if (cmd_v) begin
        int_r <= 1'b0;
      end
      if (at_thr) begin
        await_r <= 1'b1;
      end else if (cmd_v || late_trig) begin
        await_r <= 1'b0;
      end
      if (cmd_v && await_r && is_rdff) begin
        reading_r <= 1'b1;
      end else if (ff_empty) begin
        reading_r <= 1'b0;
      end
      if (late_trig || (cmd_v && await_r && !is_rdff && !rpt_mode)) begin
        clr_pend_r <= 1'b1;
      end else if (push) begin
        clr_pend_r <= 1'b0;
      end
      if (at_thr) begin
        irq_done_r <= 1'b1;
      end else if (svc_clr || (push && clr_pend_r) || ff_empty) begin
        irq_done_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // result store
  assign ff.wr_en   = push;
  assign ff.wr_data = adc_result_i;
  assign ff.rd_en   = is_rdff;
  assign ff.clr     = is_wrcfg || svc_clr ||
                      (push && clr_pend_r);

  acs_fifo u_fifo (
    .clk_i (core_clk_i),
    .rst_i (sys_rst_i),
    .f     (ff.store)
  );

  ////////////////////////////////////////////////////////////////////
  // serial answer word
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      last_res_r <= '0;
      tx_word_r  <= '0;
      tx_tog_r   <= 1'b0;
    end else begin
      if (conv_done) begin
        last_res_r <= adc_result_i;
      end
      if (cmd_v) begin
        tx_tog_r <= ~tx_tog_r;
        if (is_rdff) begin
          tx_word_r <= {ff.rd_data, 4'h0};
        end else if (is_rdcfg) begin
          tx_word_r <= {4'h0, cfg_r};
        end else begin
          tx_word_r <= {last_res_r, 4'h0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      adc_sample_o           <= 1'b0;
      adc_convert_o          <= 1'b0;
      adc_channel_o          <= '0;
      conversion_done_flag_o <= 1'b0;
      threshold_irq_n_o      <= 1'b1;
      status_pin_o           <= 1'b1;
      fifo_count_o           <= '0;
    end else begin
      adc_sample_o  <= state_nxt == ST_SAMPX || state_nxt == ST_SAMPN;
      adc_convert_o <= state_r != ST_CONV && state_nxt == ST_CONV;
      adc_channel_o <= swp_mode ? {1'b0, seq_ch(seq_w, seq_idx_r)} :
                       chan_r;
      conversion_done_flag_o <= state_nxt == ST_CONV;
      threshold_irq_n_o      <= ~int_r;
      status_pin_o <= (!ff_mode && pin_sel) ? state_nxt != ST_CONV :
                      ~int_r;
      fifo_count_o <= ff.count;
    end
  end
endmodule

// ===== acs_seq_checker.sv
/*
  acs_seq_checker: port timing relations of the conversion-mode sequencer.
  Assumes it is bound onto acs_seq, with both clocks running in reset.
*/
`timescale 1ns/1ps
module acs_seq_checker
  import acs_pkg::*;
(
  input wire logic             core_clk_i,
  input wire logic             sys_rst_i,
  input wire logic             link_clk_i,
  input wire logic             cs_n_i,
  input wire logic             conv_start_n_i,
  input wire logic             adc_done_i,
  input wire logic             adc_sample_o,
  input wire logic             adc_convert_o,
  input wire logic             conversion_done_flag_o,
  input wire logic             threshold_irq_n_o,
  input wire logic             status_pin_o,
  input wire logic [CNT_W-1:0] fifo_count_o,
  input wire logic             sdo_oe_o
);
  ////////////////////////////////////////////////////////////
  property p_rst_val;
    @(posedge core_clk_i) disable iff (sys_rst_i) $past(sys_rst_i) |->
      threshold_irq_n_o && fifo_count_o == 4'h0 && !conversion_done_flag_o;
  endproperty
  a_rst_val:
    assert property (p_rst_val) else $error("outputs not at reset values");
  property p_conv_samp;
    @(posedge core_clk_i) disable iff (sys_rst_i) adc_convert_o |-> $past(adc_sample_o);
  endproperty
  a_conv_samp:
    assert property (p_conv_samp) else $error("convert without sampling");
  property p_conv_pulse;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      adc_convert_o |-> conversion_done_flag_o ##1 !adc_convert_o;
  endproperty
  a_conv_pulse:
    assert property (p_conv_pulse) else $error("convert pulse or flag wrong");
  property p_flag_hold;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      conversion_done_flag_o && !adc_done_i |=> conversion_done_flag_o;
  endproperty
  a_flag_hold:
    assert property (p_flag_hold) else $error("busy flag dropped early");
  property p_flag_end;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      conversion_done_flag_o && adc_done_i |=> !conversion_done_flag_o;
  endproperty
  a_flag_end:
    assert property (p_flag_end) else $error("busy flag stuck after done");
  property p_ext_conv;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(conv_start_n_i) && adc_sample_o |-> ##[1:6] adc_convert_o;
  endproperty
  a_ext_conv:
    assert property (p_ext_conv) else $error("no convert after start pin rise");
  property p_ext_hold;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      adc_sample_o && !conv_start_n_i |=> adc_sample_o;
  endproperty
  a_ext_hold:
    assert property (p_ext_hold) else $error("sampling ended with start pin low");
  property p_cnt_step;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      fifo_count_o > $past(fifo_count_o) |-> fifo_count_o == $past(fifo_count_o) + 4'h1
      && ($past(adc_done_i) || $past(adc_done_i, 2));
  endproperty
  a_cnt_step:
    assert property (p_cnt_step) else $error("fill count rose without a result");
  property p_irq_src;
    @(posedge core_clk_i) disable iff (sys_rst_i) $fell(threshold_irq_n_o) |->
      $past(adc_done_i) || $past(adc_done_i, 2) || $past(adc_done_i, 3);
  endproperty
  a_irq_src:
    assert property (p_irq_src) else $error("irq without a finished conversion");
  property p_stat_src;
    @(posedge core_clk_i) disable iff (sys_rst_i) !status_pin_o |->
      !threshold_irq_n_o || conversion_done_flag_o || $past(conversion_done_flag_o);
  endproperty
  a_stat_src:
    assert property (p_stat_src) else $error("status pin low without cause");
  property p_oe_cs;
    @(posedge link_clk_i) disable iff (sys_rst_i) sdo_oe_o == !$past(cs_n_i);
  endproperty
  a_oe_cs:
    assert property (p_oe_cs) else $error("output enable not following select");
endmodule

bind acs_seq acs_seq_checker u_chk (.*);

// ===== acs_seq_tb.sv
/*
  acs_seq_tb: self-checking bench of the conversion-mode sequencer.
  Assumes acs_host_model as host and a simple analog core model here.
*/
`timescale 1ns/1ps
module acs_seq_tb;
  import acs_pkg::*;
  logic             core_clk_i;
  logic             sys_rst_i;
  logic             link_clk_i;
  logic             cs_n_i;
  logic             frame_sync_in_i;
  logic             sdi_i;
  logic             sdo_o;
  logic             sdo_oe_o;
  logic             conv_start_n_i;
  logic             adc_done_i;
  logic [RES_W-1:0] adc_result_i;
  logic             adc_sample_o;
  logic             adc_convert_o;
  logic [CH_W-1:0]  adc_channel_o;
  logic             conversion_done_flag_o;
  logic             threshold_irq_n_o;
  logic             status_pin_o;
  logic [CNT_W-1:0] fifo_count_o;
  logic [4:0]       cnv;
  logic [3:0]       ch_l;
  logic [15:0]      r;
  int               n_fail = 0;
  int               total_checks = 0;
  logic [11:0]      cfg_tab [4] = '{12'h042, 12'h04b, 12'h051, 12'h058};
  logic [3:0]       thr_tab [4] = '{THR_HALF, THR_1Q, THR_3Q, THR_FULL};

  acs_seq dut (.*);
  acs_host_model host (
    .link_clk_o(link_clk_i),
    .cs_n_o    (cs_n_i),
    .fs_o      (frame_sync_in_i),
    .sdi_o     (sdi_i),
    .conv_start_n_n_o(conv_start_n_i),
    .sdo_i     (sdo_o)
  );
  ////////////////////////////////////////////////////////////
  always #4 core_clk_i = ~core_clk_i;
  // analog core: result 19 cycles after convert, noise otherwise
  always @(posedge core_clk_i) begin
    #1;
    adc_done_i = 1'b0;
    adc_result_i = ~adc_result_i;
    if (adc_convert_o === 1'b1) begin
      cnv = 5'd20;
      ch_l = adc_channel_o;
    end else if (cnv == 5'd1) begin
      adc_done_i = 1'b1;
      adc_result_i = res_of(ch_l);
    end
    if (cnv != 5'd0) cnv = cnv - 5'd1;
  end
  function automatic logic [11:0] res_of(input logic [3:0] ch);
    return {8'h5a, ch};
  endfunction
  function automatic logic [3:0] ch_of(input logic [1:0] s, input int i);
    case (s)
      2'b00: return 4'(i);
      2'b01: return 4'((2 * i) % 8);
      2'b10: return 4'(i & 6);
      default: return 4'((i % 2) * 2);
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wait_conv(input int lim);
    int n;
    n = 0;
    while (adc_convert_o !== 1'b1 && n < lim) begin
      wait_cyc(1);
      n++;
    end
    chk(n < lim, 1'b1);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    n_fail++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    adc_done_i = 1'b0;
    adc_result_i = 12'h000;
    cnv = 5'd0;
    ch_l = 4'h0;
    fork
      host.clk(10);
      begin
        wait_cyc(20);
        chk({threshold_irq_n_o, status_pin_o, fifo_count_o}, 16'h30);
        sys_rst_i = 1'b0;
      end
    join
    // sweep rows: sequence, threshold, order of results
    for (int k = 0; k < 4; k++) begin
      host.xfer({CMD_WR_CFG, cfg_tab[k]}, r);
      repeat (8) begin
        host.cs_trig();
        wait_cyc(140);
      end
      chk(fifo_count_o, thr_tab[k]);
      chk(threshold_irq_n_o, 1'b0);
      host.xfer({CMD_RD_FIFO, 12'h000}, r);
      for (int i = 0; i < thr_tab[k]; i++) begin
        host.xfer({(i + 1 < thr_tab[k]) ? CMD_RD_FIFO : 4'hf, 12'h000}, r);
        chk(r, {res_of(ch_of(cfg_tab[k][4:3], i)), 4'h0});
      end
      host.cs_trig();
      wait_cyc(140);
      chk(fifo_count_o, 4'h0);
    end
    // repeat mode: select starts it, unread data is dropped on service
    host.xfer({CMD_WR_CFG, 12'h023}, r);
    host.xfer(16'h2000, r);
    wait_cyc(140);
    chk(fifo_count_o, 4'h1);
    repeat (2) begin
      host.cs_trig();
      wait_cyc(140);
    end
    chk(fifo_count_o, THR_1Q);
    chk(threshold_irq_n_o, 1'b0);
    host.xfer(16'h2000, r);
    chk(fifo_count_o, 4'h0);
    host.cs_trig();
    wait_cyc(140);
    chk(fifo_count_o, 4'h1);
    chk(threshold_irq_n_o, 1'b1);
    host.cs_trig();
    wait_cyc(140);
    chk(threshold_irq_n_o, 1'b0);
    // one-shot, pin as end of conversion, then extended sampling
    host.xfer({CMD_WR_CFG, 12'h004}, r);
    host.xfer(16'h3000, r);
    wait_conv(300);
    wait_cyc(2);
    chk(status_pin_o, 1'b0);
    chk(conversion_done_flag_o, 1'b1);
    wait_cyc(30);
    chk(status_pin_o, 1'b1);
    chk(fifo_count_o, 4'h0);
    fork
      host.conv_start_n(800);
      begin
        wait_cyc(20);
        chk(adc_sample_o, 1'b1);
      end
    join
    wait_conv(8);
    // one-shot with interrupt, served by select and read
    host.xfer({CMD_WR_CFG, 12'h000}, r);
    host.xfer(16'h5000, r);
    wait_conv(300);
    wait_cyc(30);
    chk(threshold_irq_n_o, 1'b0);
    chk(status_pin_o, 1'b0);
    host.xfer(16'hf000, r);
    chk(threshold_irq_n_o, 1'b1);
    host.xfer(16'hf000, r);
    chk(r, {res_of(4'h5), 4'h0});
    // repeat sweep by frame sync, past the threshold
    host.xfer({CMD_WR_CFG, 12'h063}, r);
    for (int t = 1; t <= 3; t++) begin
      host.fs_trig();
      wait_cyc(140);
      chk(fifo_count_o, (t == 3) ? 4'h1 : 4'(t));
    end
    chk(threshold_irq_n_o, 1'b0);
    fork
      host.conv_start_n(800);
      begin
        wait_cyc(20);
        chk(adc_sample_o, 1'b0);
      end
    join
    fork
      host.xfer(16'hf000, r);
      begin
        wait_cyc(74);
        chk(fifo_count_o, 4'h0);
      end
    join
    print_verdict();
  end
endmodule
